// file: rtl/wrf_top.sv
// Function
// - Brown-out flag set on event, cleared by POR/write0
// - Pin flag set on event, cleared by POR/write0
// - Power-on flag set by POR, write0 clears
// - Select field at bits 5 and 2..0
// - Time-out in interrupt modes sets flag
// - Vector ack or write-one clears flag
// - Interrupt needs global enable, enable, flag
// - Enable bits choose stopped/irq/reset/combined mode
// - Programmed fuse forces reset mode
// - Combined-mode vector clears enable and flag
// - Unserviced combined time-out causes reset
// - Reset-enable clear, select change need unlock
// - Unlock bit self-clears after four cycles
// - Watchdog cause flag forces reset-enable set
// - Codes 0..9 give 2048..1048576 oscillator cycles
// - Watchdog reset sets cause flag
// - Counter advances on watchdog oscillator cycles
// - Restart command clears the counter
module wrf_top #(
    parameter int OSC_BASE_LOG2 = wrf_pkg::BASE_LOG2,
    parameter int COUNT_W       = wrf_pkg::CNT_W
) (
    input  wire logic       ref_clk_in,
    input  wire logic       resetn_in,
    input  wire logic       sys_reset_in,
    input  wire logic       wd_osc_in,
    input  wire logic       always_on_fuse_in,
    input  wire logic       brownout_event_in,
    input  wire logic       pin_reset_event_in,
    input  wire logic       restart_in,
    input  wire logic       vector_ack_in,
    input  wire logic       global_irq_enable_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    output logic            irq_out,
    output logic            wd_reset_out
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Refused while elaborating, so a bad width never reaches a netlist.
    if (OSC_BASE_LOG2 < 1 || COUNT_W < OSC_BASE_LOG2 + 9 || COUNT_W > 31) begin : g_bad_width
        $error("wrf_top: counter width cannot hold the longest time-out");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic               irq_flag_q;
    logic               irq_en_q;
    logic               rst_en_q;
    logic [3:0]         sel_q;
    logic               unlock_q;
    logic [2:0]         unlock_cnt_q;
    logic [COUNT_W-1:0] count_q;
    logic               wdog_flag_q;
    logic               brown_flag_q;
    logic               pin_flag_q;
    logic               pwr_flag_q;
    logic [7:0]         rdata_q;
    logic               irq_q;
    logic               wd_reset_q;
    logic               osc_tick;
    logic               fuse_level;
    logic               ctrl_reset;
    logic               ctrl_wr;
    logic               cause_wr;
    logic               fuse_forced;
    logic               rst_en_eff;
    logic               irq_en_eff;
    logic               running;
    logic               timeout;
    logic               to_set_flag;
    logic               to_reset;
    logic [3:0]         wsel;

    // ------------------------------------------------------------------
    // Synchronisers for the oscillator and the fuse level
    // ------------------------------------------------------------------
    // The oscillator is far slower than the system clock, so sampling it
    // and counting filtered rising edges is safe and avoids a second domain.
    wrf_sync u_osc_sync (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .async_in   (wd_osc_in),
        .level_out  (),
        .rise_out   (osc_tick)
    );

    wrf_sync u_fuse_sync (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .async_in   (always_on_fuse_in),
        .level_out  (fuse_level),
        .rise_out   ()
    );

    // ------------------------------------------------------------------
    // Mode decoding
    // ------------------------------------------------------------------
    // Time-out length in oscillator cycles minus one for a select code.
    function automatic logic [COUNT_W-1:0] limit_of(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > wrf_pkg::SEL_MAX) ? wrf_pkg::SEL_MAX : sel;
        limit_of = (COUNT_W'(1) << (OSC_BASE_LOG2 + int'(s))) - COUNT_W'(1);
    endfunction

    // The fuse reads zero when programmed; until the filter settles after
    // reset the block assumes it programmed, the safe direction.
    assign fuse_forced = ~fuse_level;
    assign rst_en_eff  = fuse_forced | rst_en_q | wdog_flag_q;
    assign irq_en_eff  = ~fuse_forced & irq_en_q;
    assign running     = rst_en_eff | irq_en_eff;
    assign ctrl_reset  = ~resetn_in | sys_reset_in;
    assign ctrl_wr     = wr_in && (addr_in == wrf_pkg::CTRL_ADDR);
    assign cause_wr    = wr_in && (addr_in == wrf_pkg::CAUSE_ADDR);
    assign wsel        = {wdata_in[wrf_pkg::CTRL_SEL_HI_BIT], wdata_in[wrf_pkg::CTRL_SEL_LO_TOP:0]};

    // ------------------------------------------------------------------
    // Time-out counter
    // ------------------------------------------------------------------
    assign timeout = running && osc_tick && (count_q >= limit_of(sel_q));

    // Counting with >= keeps a shortened select from leaving the counter
    // stranded past its new limit; it then fires at the next oscillator edge.
    always_ff @(posedge ref_clk_in) begin
        if (ctrl_reset || restart_in || !running) begin
            count_q <= '0;
        end else if (timeout) begin
            count_q <= '0;
        end else if (osc_tick) begin
            count_q <= count_q + COUNT_W'(1);
        end
    end

    // Action on time-out: interrupt first where enabled, reset otherwise or,
    // with reset enabled, when the previous interrupt is still pending.
    assign to_set_flag = timeout && irq_en_eff && !(rst_en_eff && irq_flag_q);
    assign to_reset    = timeout && (rst_en_eff && (!irq_en_eff || irq_flag_q));

    always_ff @(posedge ref_clk_in) begin
        if (ctrl_reset) begin
            wd_reset_q <= 1'b0;
        end else begin
            wd_reset_q <= to_reset;
        end
    end

    // ------------------------------------------------------------------
    // Change unlock window
    // ------------------------------------------------------------------
    // Arming needs unlock and reset-enable written as ones together; the
    // window then closes after four cycles or after the next control write.
    always_ff @(posedge ref_clk_in) begin
        if (ctrl_reset) begin
            unlock_q     <= 1'b0;
            unlock_cnt_q <= 3'h0;
        end else if (ctrl_wr && wdata_in[wrf_pkg::CTRL_UNLOCK_BIT] && wdata_in[wrf_pkg::CTRL_RST_EN_BIT]) begin
            unlock_q     <= 1'b1;
            unlock_cnt_q <= 3'(wrf_pkg::UNLOCK_CYCLES - 1);
        end else if (unlock_q && (ctrl_wr || unlock_cnt_q == 3'h0)) begin
            unlock_q     <= 1'b0;
            unlock_cnt_q <= 3'h0;
        end else if (unlock_q) begin
            unlock_cnt_q <= unlock_cnt_q - 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    // Reset-enable can always be set; clearing needs an open window.
    always_ff @(posedge ref_clk_in) begin
        if (ctrl_reset) begin
            rst_en_q <= 1'b0;
            sel_q    <= wrf_pkg::SEL_RESET;
        end else if (ctrl_wr) begin
            if (unlock_q) begin
                rst_en_q <= wdata_in[wrf_pkg::CTRL_RST_EN_BIT];
                sel_q    <= wsel;
            end else begin
                rst_en_q <= rst_en_q | wdata_in[wrf_pkg::CTRL_RST_EN_BIT];
            end
        end
    end

    // Interrupt enable; a vector taken with reset enabled drops it so the
    // next time-out resets the device unless software re-arms it.
    always_ff @(posedge ref_clk_in) begin
        if (ctrl_reset) begin
            irq_en_q <= 1'b0;
        end else if (vector_ack_in && rst_en_eff) begin
            irq_en_q <= 1'b0;
        end else if (ctrl_wr) begin
            irq_en_q <= wdata_in[wrf_pkg::CTRL_IRQ_EN_BIT];
        end
    end

    // Interrupt flag: a time-out in the same cycle as a clear wins.
    always_ff @(posedge ref_clk_in) begin
        if (ctrl_reset) begin
            irq_flag_q <= 1'b0;
        end else if (to_set_flag) begin
            irq_flag_q <= 1'b1;
        end else if (vector_ack_in || (ctrl_wr && wdata_in[wrf_pkg::CTRL_IRQ_FLAG_BIT])) begin
            irq_flag_q <= 1'b0;
        end
    end

    // Interrupt request to the core, registered.
    always_ff @(posedge ref_clk_in) begin
        if (ctrl_reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_flag_q & irq_en_eff & global_irq_enable_in;
        end
    end

    // ------------------------------------------------------------------
    // Reset cause flags
    // ------------------------------------------------------------------
    // Only the power-on reset reaches these; other resets leave them so
    // software can tell what happened. Events win over a write of zero.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            pwr_flag_q   <= 1'b1;
            brown_flag_q <= 1'b0;
            pin_flag_q   <= 1'b0;
            wdog_flag_q  <= 1'b0;
        end else begin
            if (cause_wr && !wdata_in[wrf_pkg::CAUSE_PWR_BIT]) begin
                pwr_flag_q <= 1'b0;
            end
            if (brownout_event_in) begin
                brown_flag_q <= 1'b1;
            end else if (cause_wr && !wdata_in[wrf_pkg::CAUSE_BROWN_BIT]) begin
                brown_flag_q <= 1'b0;
            end
            if (pin_reset_event_in) begin
                pin_flag_q <= 1'b1;
            end else if (cause_wr && !wdata_in[wrf_pkg::CAUSE_PIN_BIT]) begin
                pin_flag_q <= 1'b0;
            end
            if (wd_reset_q) begin
                wdog_flag_q <= 1'b1;
            end else if (cause_wr && !wdata_in[wrf_pkg::CAUSE_WDOG_BIT]) begin
                wdog_flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Data stand for one cycle after the read strobe, zero otherwise and
    // for unmapped addresses. Fuse-locked bits read as their forced values.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            rdata_q <= wrf_pkg::RDATA_RESET;
        end else if (rd_in && addr_in == wrf_pkg::CTRL_ADDR) begin
            rdata_q <= {irq_flag_q, irq_en_eff, sel_q[3], unlock_q, rst_en_eff, sel_q[2:0]};
        end else if (rd_in && addr_in == wrf_pkg::CAUSE_ADDR) begin
            rdata_q <= {4'h0, wdog_flag_q, brown_flag_q, pin_flag_q, pwr_flag_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_out    = rdata_q;
    assign irq_out      = irq_q;
    assign wd_reset_out = wd_reset_q;

endmodule

// file: inc/wrf_pkg.sv
package wrf_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR   = 8'h60;  // Watchdog control and status.
    localparam logic [7:0] CAUSE_ADDR  = 8'h54;  // Reset cause status.

    // ------------------------------------------------------------------
    // Field positions of watchdog_control_status
    // ------------------------------------------------------------------
    localparam int CTRL_IRQ_FLAG_BIT   = 7;
    localparam int CTRL_IRQ_EN_BIT     = 6;
    localparam int CTRL_SEL_HI_BIT     = 5;
    localparam int CTRL_UNLOCK_BIT     = 4;
    localparam int CTRL_RST_EN_BIT     = 3;
    localparam int CTRL_SEL_LO_TOP     = 2;

    // ------------------------------------------------------------------
    // Field positions of reset_cause_status
    // ------------------------------------------------------------------
    localparam int CAUSE_WDOG_BIT      = 3;
    localparam int CAUSE_BROWN_BIT     = 2;
    localparam int CAUSE_PIN_BIT       = 1;
    localparam int CAUSE_PWR_BIT       = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] SEL_RESET   = 4'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Timing and counts
    // ------------------------------------------------------------------
    localparam int         CLK_PERIOD_NS   = 5;     // System clock 200 MHz.
    localparam int         OSC_FREQ_KHZ    = 128;   // Nominal watchdog oscillator.
    localparam int         UNLOCK_CYCLES   = 4;     // Change window in system clocks.
    localparam int         BASE_LOG2       = 11;    // Shortest time-out is 2048 cycles.
    localparam logic [3:0] SEL_MAX         = 4'h9;  // Longest defined select code.
    localparam int         CNT_W           = 20;    // Holds 1048576 - 1.

endpackage

// file: rtl/wrf_sync.sv
// ----------------------------------------------------------------------
// Three-stage input synchroniser with agreement filter
// ----------------------------------------------------------------------
module wrf_sync (
    input  wire logic ref_clk_in,
    input  wire logic resetn_in,
    input  wire logic async_in,
    output logic      level_out,
    output logic      rise_out
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic rise_q;

    // The first stage feeds only the second, so metastability stays contained.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once stages two and three agree.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            level_q <= 1'b0;
            rise_q  <= 1'b0;
        end else begin
            rise_q <= 1'b0;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
                rise_q  <= s3_q & ~level_q;
            end
        end
    end

    assign level_out = level_q;
    assign rise_out  = rise_q;

endmodule

// file: sim/wrf_top_sva.sv
// --------
// Port-level checker for the watchdog block
// --------
module wrf_chk (
    input  wire logic       ref_clk_in,
    input  wire logic       resetn_in,
    input  wire logic       global_irq_enable_in,
    input  wire logic       vector_ack_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic [7:0] rdata_out,
    input  wire logic       irq_out,
    input  wire logic       wd_reset_out
);
    // One clock domain, so clocking and reset are given once here.
    default clocking dc @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    // Bus cycles that the change-window checks are built from.
    sequence unlock_wr;
        wr_in && addr_in == wrf_pkg::CTRL_ADDR && wdata_in[4:3] == 2'b11;
    endsequence
    sequence ctrl_rd;
        rd_in && addr_in == wrf_pkg::CTRL_ADDR;
    endsequence

    AST_RDATA_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data not zero outside a read answer");
    AST_UNMAPPED_RD: assert property (rd_in && addr_in != wrf_pkg::CTRL_ADDR && addr_in != wrf_pkg::CAUSE_ADDR
        |=> rdata_out == 8'h00) else $error("unmapped read returned data");
    AST_CAUSE_TOP: assert property (rd_in && addr_in == wrf_pkg::CAUSE_ADDR |=> rdata_out[7:4] == 4'h0)
        else $error("unused cause bits read nonzero");
    AST_RST_PULSE: assert property (wd_reset_out |=> !wd_reset_out)
        else $error("watchdog reset pulse longer than one cycle");
    AST_IRQ_GIE: assert property (irq_out |-> $past(global_irq_enable_in))
        else $error("interrupt raised without global enable");
    AST_UNLOCK_OPEN: assert property (unlock_wr ##1 !wr_in ##1 ctrl_rd |=> rdata_out[4])
        else $error("change window closed too early");
    AST_UNLOCK_SHUT: assert property (unlock_wr ##1 (!wr_in) [*4] ##1 ctrl_rd |=> !rdata_out[4])
        else $error("change window still open after four cycles");
    AST_ACK_IRQ: assert property (vector_ack_in |-> ##2 !irq_out)
        else $error("interrupt still raised after vector executed");
    AST_WD_CAUSE: assert property (wd_reset_out ##1 rd_in && addr_in == wrf_pkg::CAUSE_ADDR |=> rdata_out[3])
        else $error("watchdog cause flag not set after watchdog reset");

    COV_IRQ_ACK: cover property (irq_out ##1 vector_ack_in);
    COV_WD_RST: cover property (wd_reset_out);
    COV_UNLOCK: cover property (unlock_wr ##2 ctrl_rd);
endmodule

bind wrf_top wrf_chk u_chk (
    .ref_clk_in, .resetn_in, .global_irq_enable_in, .vector_ack_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .irq_out, .wd_reset_out
);

// file: sim/wrf_tb_top.sv
module wrf_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // --------
    // Signals and design
    // --------
    localparam logic [7:0] CT = wrf_pkg::CTRL_ADDR;
    localparam logic [7:0] CS = wrf_pkg::CAUSE_ADDR;
    localparam int         SR = 0, BO = 1, PN = 2, RS = 3, AK = 4;
    localparam real        OSC_CYC = 8.12;  // Oscillator period in clocks, kept off a whole number on purpose.

    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       osc = 1'b0;
    logic       fuse = 1'b1;
    logic       gie = 1'b0;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [4:0] ev = 5'h00;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       irq;
    logic       wdrst;
    int         fail_count = 0;
    int         num_checks = 0;
    int         rst_seen = 0;

    // A base of 2 turns the shortest time-out into 4 oscillator cycles.
    wrf_top #(.OSC_BASE_LOG2(2), .COUNT_W(11)) uut (
        .ref_clk_in(clk), .resetn_in(resetn), .sys_reset_in(ev[SR]), .wd_osc_in(osc),
        .always_on_fuse_in(fuse), .brownout_event_in(ev[BO]), .pin_reset_event_in(ev[PN]),
        .restart_in(ev[RS]), .vector_ack_in(ev[AK]), .global_irq_enable_in(gie),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .irq_out(irq), .wd_reset_out(wdrst)
    );

    // System clock, and a slow oscillator whose edges meet a rising clock edge only once in 50.
    initial forever #2.5 clk = ~clk;
    initial begin
        #3.3;
        forever #20.3 osc = ~osc;
    end
    always @(posedge clk) if (wdrst === 1'b1) rst_seen++;

    // --------
    // Shared tasks
    // --------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev <= ev | (5'h01 << i);
        @(posedge clk);
        ev <= ev & ~(5'h01 << i);
    endtask
    // Bounded wait for the interrupt (sel 0) or the reset pulse (sel 1).
    task automatic wait_for(input bit sel, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while ((sel ? wdrst : irq) !== 1'b1 && n < 40000);
    endtask
    task automatic por();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
    endtask
    // System reset plus cause clear; must follow a reset pulse quickly or the next time-out re-arms it.
    task automatic disarm();
        pulse(SR);
        wr_reg(CS, 8'h00);
        rd_chk(CT, 8'h00);
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // --------
    // Scenarios
    // --------
    task automatic test_flags();
        rd_chk(CS, 8'h01);
        rd_chk(CT, 8'h00);
        rd_chk(8'h55, 8'h00);
        repeat (200) @(posedge clk);
        chk({irq, 6'h00, rst_seen != 0}, 8'h00);
        pulse(BO);
        pulse(PN);
        rd_chk(CS, 8'h07);
        wr_reg(CS, 8'h05);
        rd_chk(CS, 8'h05);
        pulse(SR);
        wr_reg(CS, 8'hff);
        rd_chk(CS, 8'h05);
        wr_reg(CS, 8'h04);
        rd_chk(CS, 8'h04);
        por();
        rd_chk(CS, 8'h01);
        $display("done: cause flags");
    endtask
    task automatic test_irq();
        int n;
        wr_reg(CT, 8'h40);
        repeat (100) @(posedge clk);
        rd_chk(CT, 8'hc0);
        chk({7'h00, irq}, 8'h00);
        @(posedge clk);
        gie <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({7'h00, irq}, 8'h01);
        pulse(RS);
        pulse(AK);
        rd_chk(CT, 8'h40);
        wait_for(1'b0, n);
        wr_reg(CT, 8'hc0);
        rd_chk(CT, 8'h40);
        chk({7'h00, irq}, 8'h00);
        wr_reg(CT, 8'h00);
        $display("done: interrupt mode");
    endtask
    task automatic test_lock();
        int n;
        wr_reg(CT, 8'h08);
        repeat (20) begin
            pulse(RS);
            repeat (14) @(posedge clk);
        end
        chk({7'h00, rst_seen != 0}, 8'h00);
        pulse(RS);
        wr_reg(CT, 8'h00);
        rd_chk(CT, 8'h08);
        wr_reg(CT, 8'h09);
        rd_chk(CT, 8'h08);
        pulse(RS);
        wr_reg(CT, 8'h18);
        repeat (3) @(posedge clk);
        rd_chk(CT, 8'h08);
        wr_reg(CT, 8'h00);
        rd_chk(CT, 8'h08);
        pulse(RS);
        wr_reg(CT, 8'h18);
        rd_chk(CT, 8'h18);
        wr_reg(CT, 8'h00);
        rd_chk(CT, 8'h00);
        wr_reg(CT, 8'h08);
        wait_for(1'b1, n);
        rd_chk(CS, 8'h09);
        chk({7'h00, n < 200}, 8'h01);
        pulse(SR);
        rd_chk(CT, 8'h08);
        wr_reg(CT, 8'h18);
        wr_reg(CT, 8'h00);
        rd_chk(CT, 8'h08);
        pulse(RS);
        wr_reg(CS, 8'h00);
        wr_reg(CT, 8'h18);
        wr_reg(CT, 8'h00);
        rd_chk(CT, 8'h00);
        $display("done: change protection");
    endtask
    task automatic test_comb();
        int n;
        int k;
        wr_reg(CT, 8'h48);
        pulse(RS);
        wait_for(1'b0, n);
        rd_chk(CT, 8'hc8);
        pulse(AK);
        rd_chk(CT, 8'h08);
        wait_for(1'b1, n);
        chk({7'h00, n < 200}, 8'h01);
        disarm();
        wr_reg(CT, 8'h48);
        pulse(RS);
        wait_for(1'b0, n);
        // Re-arming after the vector keeps combined mode: the next time-out interrupts again.
        pulse(AK);
        wr_reg(CT, 8'h48);
        k = rst_seen;
        wait_for(1'b0, n);
        chk({7'h00, n < 200 && rst_seen == k}, 8'h01);
        wait_for(1'b1, n);
        chk({7'h00, n < 200}, 8'h01);
        disarm();
        $display("done: combined mode");
    endtask
    task automatic test_fuse();
        int n;
        @(posedge clk);
        fuse <= 1'b0;
        wr_reg(CT, 8'h40);
        repeat (8) @(posedge clk);
        rd_chk(CT, 8'h08);
        wait_for(1'b1, n);
        chk({7'h00, n < 200}, 8'h01);
        @(posedge clk);
        fuse <= 1'b1;
        repeat (8) @(posedge clk);
        disarm();
        $display("done: fuse");
    endtask
    // Codes run upward so the limit never shortens between measurements.
    task automatic test_sel();
        int n;
        for (int k = 0; k < 11; k++) begin
            logic [3:0] c;
            real        e;
            c = (k < 10) ? 4'(k) : 4'hf;
            e = (4 << ((k < 10) ? k : 9)) * OSC_CYC;
            pulse(RS);
            wr_reg(CT, 8'h18);
            wr_reg(CT, {2'b11, c[3], 2'b00, c[2:0]});
            pulse(RS);
            wait_for(1'b0, n);
            // A restart lands anywhere inside an oscillator period, so the first counted cycle may be short.
            chk({7'h00, n > e - OSC_CYC - 2.0 && n < e + 20.0}, 8'h01);
        end
        wr_reg(CT, 8'h00);
        $display("done: time-out select");
    endtask

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
        test_flags();
        test_irq();
        test_lock();
        test_comb();
        test_fuse();
        test_sel();
        summarize();
    end
    // Whole run needs about 55000 cycles; this leaves ample margin.
    initial begin
        #400000;
        fail_count++;
        summarize();
    end
endmodule
